// ==== pkg/lpc_pkg.sv ====
/*
 * Constants, register map and state type for the low power clock
 * controller. Assumes a 200 MHz system clock and a 12-bit register window
 * decoded from the low bits of the bus address.
 */
package lpc_pkg;

  // register byte offsets within the controller window
  localparam logic [11:0] OFF_TIMER_LO = 12'h400;
  localparam logic [11:0] OFF_TIMER_HI = 12'h404;
  localparam logic [11:0] OFF_TIMER_GO = 12'h408;
  localparam logic [11:0] OFF_ALARM_LO = 12'h410;
  localparam logic [11:0] OFF_ALARM_HI = 12'h414;
  localparam logic [11:0] OFF_ALARM_GO = 12'h418;
  localparam logic [11:0] OFF_PLL_LP   = 12'h420;
  localparam logic [11:0] OFF_LINK_DIS = 12'h428;
  localparam logic [11:0] OFF_WD_SEL   = 12'h42C;
  localparam logic [11:0] OFF_STATUS   = 12'h430;
  localparam logic [11:0] OFF_RATIO    = 12'h500;

  localparam int TIMER_W    = 64;
  localparam int ALARM_W    = 40;
  localparam int ALARM_HI_W = 8;
  localparam int RATIO_W    = 6;

  // status register bit positions
  localparam int ST_STOPPED   = 0;
  localparam int ST_TIMER_RUN = 1;
  localparam int ST_ALARM_RUN = 2;
  localparam int ST_WD_LOW    = 3;
  localparam int ST_STRAP_LO  = 4;

  // strap codes and the multiply ratio reported for each
  localparam logic [1:0] STRAP_BYPASS = 2'h0;
  localparam logic [RATIO_W-1:0] RATIO_X1   = 6'h01;
  localparam logic [RATIO_W-1:0] RATIO_X123 = 6'h04;
  localparam logic [RATIO_W-1:0] RATIO_X148 = 6'h05;
  localparam logic [RATIO_W-1:0] RATIO_X185 = 6'h06;

  // reset values
  localparam logic [1:0] PLL_LP_RST   = 2'h3;
  localparam logic [1:0] PLL_FULL_ON  = 2'h3;
  localparam logic       LINK_DIS_RST = 1'b0;
  localparam logic       WD_SEL_RST   = 1'b0;

  // alarm value at which the watchdog pulse is raised by the next tick
  localparam logic [ALARM_W-1:0] WD_FIRE_FROM = 40'h00_0000_0002;

  typedef enum logic {PWR_RUN, PWR_DOWN} lpc_pwr_e;

endpackage

// ==== design/lpc_tick_sync.sv ====
/*
 * Brings the slow timebase input into the system clock domain and turns
 * each rising edge into a one-cycle tick. Assumes the slow input runs at
 * no more than one eighth of the system clock, so no edge is missed.
 */
`timescale 1ns/1ps
module lpc_tick_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic slow_in,
  output logic      tick
);

  logic meta;
  logic stable;
  logic last;
  logic next_tick;

  // meta feeds only stable; the edge is taken between stable and last
  always_comb begin
    next_tick = stable & ~last;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
      tick   <= 1'b0;
    end else begin
      meta   <= slow_in;
      stable <= meta;
      last   <= stable;
      tick   <= next_tick;
    end
  end

endmodule

// ==== design/lpc_clock_ctrl.sv ====
/*
 * Low power clock controller: strap driven clock rate selection,
 * power-down sequencing of the global clocks, a 64-bit real time counter
 * and a 40-bit alarm that doubles as a watchdog, all behind an AHB-Lite
 * slave. Assumes one bus master, word accesses only, and a slow timebase
 * at most one eighth of CLK_SYS.
 */
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module lpc_clock_ctrl (
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [1:0]  CPU_RATE_STRAP,
  input  wire logic        SLOW_TIMEBASE_INPUT,
  input  wire logic        IRQ_PENDING,
  input  wire logic        INTERRUPT_PIN,
  input  wire logic        LINK_ACTIVE,
  output logic             PLL_BYPASS_MODE,
  output logic      [1:0]  PLL_MULT_SEL,
  output logic      [1:0]  PLL_LP_STATE,
  output logic             GLOBAL_CLK_EN,
  output logic             CLOCKS_STOPPED_PIN,
  output logic             WATCHDOG_RESET_N
);

  localparam int TW = lpc_pkg::TIMER_W;
  localparam int AW = lpc_pkg::ALARM_W;

  logic                 lp_tick;
  logic [1:0]           strap_q;
  lpc_pkg::lpc_pwr_e    pwr;
  lpc_pkg::lpc_pwr_e    next_pwr;
  logic [TW-1:0]        timer;
  logic [TW-1:0]        next_timer;
  logic                 timer_run;
  logic                 next_timer_run;
  logic [AW-1:0]        alarm;
  logic [AW-1:0]        next_alarm;
  logic                 alarm_run;
  logic                 next_alarm_run;
  logic [1:0]           pll_lp_cfg;
  logic [1:0]           next_pll_lp_cfg;
  logic                 link_wake_disable;
  logic                 next_link_wake_disable;
  logic                 watchdog_select;
  logic                 next_watchdog_select;
  logic                 wake_seen;
  logic                 next_wake_seen;
  logic                 wr_pend;
  logic                 next_wr_pend;
  logic [11:0]          wr_addr;
  logic [11:0]          next_wr_addr;
  logic [31:0]          next_hrdata;
  logic                 next_wd_n;
  logic                 alarm_start_write;
  logic                 timer_word_write;
  logic                 alarm_word_write;
  logic                 down_blocked;
  logic                 expire;
  logic                 wake_src;

  function automatic logic [lpc_pkg::RATIO_W-1:0] ratio_of(
    input logic [1:0] s);
    case (s)
      2'h1:    ratio_of = lpc_pkg::RATIO_X123;
      2'h2:    ratio_of = lpc_pkg::RATIO_X148;
      2'h3:    ratio_of = lpc_pkg::RATIO_X185;
      default: ratio_of = lpc_pkg::RATIO_X1;
    endcase
  endfunction

  function automatic logic wr_hit(input logic p, input logic [11:0] a,
                                  input logic [11:0] off);
    wr_hit = p && (a == off);
  endfunction

  lpc_tick_sync u_tick (
    .clk     (CLK_SYS),
    .srst    (SRST),
    .slow_in (SLOW_TIMEBASE_INPUT),
    .tick    (lp_tick)
  );

  // bus side: address phase is latched, write lands in the data phase
  always_comb begin
    next_wr_pend = HSEL && HREADY && HTRANS[1] && HWRITE;
    next_wr_addr = HADDR[11:0];
    next_hrdata  = 32'h0000_0000;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[11:0])
        lpc_pkg::OFF_TIMER_LO: next_hrdata = timer[31:0];
        lpc_pkg::OFF_TIMER_HI: next_hrdata = timer[63:32];
        lpc_pkg::OFF_ALARM_LO: next_hrdata = alarm[31:0];
        lpc_pkg::OFF_ALARM_HI: next_hrdata = {24'h00_0000, alarm[39:32]};
        lpc_pkg::OFF_PLL_LP:   next_hrdata = {30'h0000_0000, pll_lp_cfg};
        lpc_pkg::OFF_LINK_DIS:
          next_hrdata = {31'h0000_0000, link_wake_disable};
        lpc_pkg::OFF_WD_SEL:
          next_hrdata = {31'h0000_0000, watchdog_select};
        lpc_pkg::OFF_RATIO:
          next_hrdata = {26'h000_0000, ratio_of(strap_q)};
        lpc_pkg::OFF_STATUS: begin
          next_hrdata[lpc_pkg::ST_STOPPED]   = CLOCKS_STOPPED_PIN;
          next_hrdata[lpc_pkg::ST_TIMER_RUN] = timer_run;
          next_hrdata[lpc_pkg::ST_ALARM_RUN] = alarm_run;
          next_hrdata[lpc_pkg::ST_WD_LOW]    = ~WATCHDOG_RESET_N;
          next_hrdata[lpc_pkg::ST_STRAP_LO +: 2] = strap_q;
        end
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign alarm_start_write = wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_ALARM_GO);
  assign timer_word_write  = wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_TIMER_LO)
                           | wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_TIMER_HI);
  assign alarm_word_write  = wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_ALARM_LO)
                           | wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_ALARM_HI);
  // an enabled busy link or a pending interrupt vetoes power-down
  assign down_blocked = IRQ_PENDING
                      | (LINK_ACTIVE & ~link_wake_disable);
  assign wake_src = IRQ_PENDING | INTERRUPT_PIN
                  | (LINK_ACTIVE & ~link_wake_disable);
  // zero is reached on the tick that leaves the count at zero
  assign expire = lp_tick && alarm_run && (alarm <= 40'h00_0000_0001);

  always_comb begin
    next_timer             = timer;
    next_timer_run         = timer_run;
    next_alarm             = alarm;
    next_alarm_run         = alarm_run;
    next_pll_lp_cfg        = pll_lp_cfg;
    next_link_wake_disable = link_wake_disable;
    next_watchdog_select   = watchdog_select;
    next_pwr               = pwr;
    next_wake_seen         = wake_seen;
    next_wd_n              = WATCHDOG_RESET_N;

    // timebase counting goes on regardless of the global clock gate
    if (lp_tick && timer_run) begin
      next_timer = timer + 64'h0000_0000_0000_0001;
    end
    if (lp_tick && alarm_run) begin
      if (expire) begin
        next_alarm     = '0;
        next_alarm_run = 1'b0;
      end else begin
        next_alarm = alarm - 40'h00_0000_0001;
      end
    end

    // low level held for exactly one slow period, tick to tick
    if (lp_tick) begin
      next_wd_n = ~(watchdog_select && alarm_run
                    && alarm == lpc_pkg::WD_FIRE_FROM);
    end

    // software writes win over a same-cycle tick
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_TIMER_LO)) begin
      next_timer[31:0] = HWDATA;
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_TIMER_HI)) begin
      next_timer[63:32] = HWDATA;
    end
    if (timer_word_write) begin
      next_timer_run = 1'b0;
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_TIMER_GO)) begin
      next_timer_run = 1'b1;
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_ALARM_LO)) begin
      next_alarm[31:0] = HWDATA;
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_ALARM_HI)) begin
      next_alarm[39:32] = HWDATA[lpc_pkg::ALARM_HI_W-1:0];
    end
    if (alarm_word_write) begin
      next_alarm_run = 1'b0;
    end
    if (alarm_start_write) begin
      next_alarm_run = 1'b1;
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_PLL_LP)) begin
      next_pll_lp_cfg = HWDATA[1:0];
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_LINK_DIS)) begin
      next_link_wake_disable = HWDATA[0];
    end
    if (wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_WD_SEL)) begin
      next_watchdog_select = HWDATA[0];
    end

    case (pwr)
      lpc_pkg::PWR_RUN: begin
        next_wake_seen = 1'b0;
        if (alarm_start_write && !watchdog_select
            && !down_blocked) begin
          next_pwr = lpc_pkg::PWR_DOWN;
        end
      end
      lpc_pkg::PWR_DOWN: begin
        // requests are held until the next slow tick acts on them
        if (wake_src) begin
          next_wake_seen = 1'b1;
        end
        if (lp_tick && (wake_seen || expire)) begin
          next_pwr       = lpc_pkg::PWR_RUN;
          next_wake_seen = 1'b0;
        end
      end
      default: next_pwr = lpc_pkg::PWR_RUN;
    endcase
  end

  // state registers other than wake_seen are never cleared by the wake itself; alarm and alarm_run also clear on expiry
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      strap_q            <= CPU_RATE_STRAP;
      pwr                <= lpc_pkg::PWR_RUN;
      timer              <= '0;
      timer_run          <= 1'b0;
      alarm              <= '0;
      alarm_run          <= 1'b0;
      pll_lp_cfg         <= lpc_pkg::PLL_LP_RST;
      link_wake_disable  <= lpc_pkg::LINK_DIS_RST;
      watchdog_select    <= lpc_pkg::WD_SEL_RST;
      wake_seen          <= 1'b0;
      wr_pend            <= 1'b0;
      wr_addr            <= 12'h000;
      HRDATA             <= 32'h0000_0000;
      HREADYOUT          <= 1'b1;
      HRESP              <= 1'b0;
      PLL_BYPASS_MODE    <= 1'b1;
      PLL_MULT_SEL       <= 2'h0;
      PLL_LP_STATE       <= lpc_pkg::PLL_FULL_ON;
      GLOBAL_CLK_EN      <= 1'b1;
      CLOCKS_STOPPED_PIN <= 1'b0;
      WATCHDOG_RESET_N   <= 1'b1;
    end else begin
      pwr                <= next_pwr;
      timer              <= next_timer;
      timer_run          <= next_timer_run;
      alarm              <= next_alarm;
      alarm_run          <= next_alarm_run;
      pll_lp_cfg         <= next_pll_lp_cfg;
      link_wake_disable  <= next_link_wake_disable;
      watchdog_select    <= next_watchdog_select;
      wake_seen          <= next_wake_seen;
      wr_pend            <= next_wr_pend;
      wr_addr            <= next_wr_addr;
      HRDATA             <= next_hrdata;
      HREADYOUT          <= 1'b1;
      HRESP              <= 1'b0;
      PLL_BYPASS_MODE    <= (strap_q == lpc_pkg::STRAP_BYPASS);
      PLL_MULT_SEL       <= strap_q;
      // PLL stops only as far as the configured low power setting says
      PLL_LP_STATE       <= (next_pwr == lpc_pkg::PWR_DOWN)
                            ? next_pll_lp_cfg : lpc_pkg::PLL_FULL_ON;
      GLOBAL_CLK_EN      <= (next_pwr == lpc_pkg::PWR_RUN);
      CLOCKS_STOPPED_PIN <= (next_pwr == lpc_pkg::PWR_DOWN);
      WATCHDOG_RESET_N   <= next_wd_n;
    end
  end

  chk_stopped_pin: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    CLOCKS_STOPPED_PIN == (pwr == lpc_pkg::PWR_DOWN)
    && GLOBAL_CLK_EN == !CLOCKS_STOPPED_PIN)
    else $error("clocks stopped pin disagrees with power state");

  chk_strap_bypass: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    $past(!SRST) |-> PLL_BYPASS_MODE == (strap_q == 2'h0)
    && PLL_MULT_SEL == strap_q)
    else $error("pll mode does not follow the strap");

  chk_enter_down: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    pwr == lpc_pkg::PWR_RUN && alarm_start_write && !watchdog_select
    && !down_blocked |=> CLOCKS_STOPPED_PIN && !GLOBAL_CLK_EN)
    else $error("alarm start did not stop the clocks");

  chk_down_blocked: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    pwr == lpc_pkg::PWR_RUN && down_blocked |=> pwr == lpc_pkg::PWR_RUN)
    else $error("power-down entered while vetoed");

  chk_wd_no_down: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    pwr == lpc_pkg::PWR_RUN && alarm_start_write && watchdog_select
    |=> GLOBAL_CLK_EN && alarm_run)
    else $error("watchdog start entered low power");

  chk_wake_exit: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    pwr == lpc_pkg::PWR_DOWN && wake_seen && lp_tick
    |=> GLOBAL_CLK_EN && !CLOCKS_STOPPED_PIN)
    else $error("wake request not acted on");

  chk_tick_exit: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    $fell(CLOCKS_STOPPED_PIN) |-> $past(lp_tick))
    else $error("clocks restarted off a slow tick");

  chk_reset_wakes: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    $past(SRST) |-> GLOBAL_CLK_EN && pwr == lpc_pkg::PWR_RUN)
    else $error("reset did not restart the clocks");

  chk_timer_count: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    lp_tick && timer_run && !timer_word_write
    |=> timer == $past(timer) + 64'h0000_0000_0000_0001)
    else $error("real time counter missed a tick");

  chk_timer_stop: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    timer_word_write && !wr_hit(wr_pend, wr_addr, lpc_pkg::OFF_TIMER_GO)
    |=> !timer_run ##1 timer == $past(timer))
    else $error("timer word write did not stop the timer");

  chk_alarm_dec: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    lp_tick && alarm_run && alarm > 40'h00_0000_0001 && !alarm_word_write
    |=> alarm == $past(alarm) - 40'h00_0000_0001)
    else $error("alarm did not step down");

  chk_wd_pulse: assert property (
    @(posedge CLK_SYS) disable iff (SRST)
    lp_tick && watchdog_select && alarm_run
    && alarm == lpc_pkg::WD_FIRE_FROM
    |=> !WATCHDOG_RESET_N throughout (!lp_tick [*1] ##1 1'b1))
    else $error("watchdog reset pulse missing");

endmodule

// ==== test/lpc_far_model.sv ====
/*
 * Far-side model: the free running slow timebase and the wake sources
 * of the core and pins (irq pending, interrupt pin, link activity).
 * Assumes the bench changes its commands just after a rising edge.
 */
`timescale 1ns/1ps
module lpc_far_model (
  input  wire logic       clk,
  input  wire logic [2:0] wake_cmd,
  output logic            slow_clk,
  output logic      [2:0] wake
);
  logic [1:0] div = 2'h0;

  initial slow_clk = 1'b0;
  initial wake = 3'h0;

  // fastest legal rate, eight system cycles a period
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      slow_clk <= ~slow_clk;
    end
    wake <= wake_cmd;
  end
endmodule

// ==== test/low_power_clock_controller_tb.sv ====
/*
 * Self-checking bench for the low power clock controller: bus tasks,
 * one task per scenario, a watchdog and the verdict.
 * Assumes lpc_pkg and the far-side model are compiled first.
 */
`timescale 1ns/1ps
module low_power_clock_controller_tb;
  logic        CLK_SYS = 1'b0;
  logic        SRST = 1'b1;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [1:0]  CPU_RATE_STRAP = 2'h0;
  logic [2:0]  wake_cmd = 3'h0;
  logic [2:0]  wake;
  logic        slow_clk;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        PLL_BYPASS_MODE;
  logic [1:0]  PLL_MULT_SEL;
  logic [1:0]  PLL_LP_STATE;
  logic        GLOBAL_CLK_EN;
  logic        CLOCKS_STOPPED_PIN;
  logic        WATCHDOG_RESET_N;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          total_checks = 0;

  always #2.5 CLK_SYS = ~CLK_SYS;

  lpc_far_model u_lpc_far_model (.clk(CLK_SYS), .wake_cmd(wake_cmd),
    .slow_clk(slow_clk), .wake(wake));

  lpc_clock_ctrl u_lpc_clock_ctrl (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CPU_RATE_STRAP(CPU_RATE_STRAP), .SLOW_TIMEBASE_INPUT(slow_clk),
    .IRQ_PENDING(wake[0]), .INTERRUPT_PIN(wake[1]),
    .LINK_ACTIVE(wake[2]), .PLL_BYPASS_MODE(PLL_BYPASS_MODE),
    .PLL_MULT_SEL(PLL_MULT_SEL), .PLL_LP_STATE(PLL_LP_STATE),
    .GLOBAL_CLK_EN(GLOBAL_CLK_EN),
    .CLOCKS_STOPPED_PIN(CLOCKS_STOPPED_PIN),
    .WATCHDOG_RESET_N(WATCHDOG_RESET_N));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // sample mid-cycle so registered outputs are settled
  task automatic wait_rdy;
    logic r;
    do begin
      @(negedge CLK_SYS);
      r = HREADYOUT;
      rd = HRDATA;
      @(posedge CLK_SYS);
    end while (r !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLK_SYS);
    HSEL <= 1'b1;
    HADDR <= {20'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= wr;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(posedge CLK_SYS);
    SRST <= 1'b1;
    CPU_RATE_STRAP <= s;
    repeat (8) @(posedge CLK_SYS);
    SRST <= 1'b0;
    // outputs load from the captured strap one edge after release
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask

  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (CLOCKS_STOPPED_PIN !== 1'b0 && n < 400);
  endtask

  task automatic start_alarm(input logic [31:0] lo);
    bus(1'b1, lpc_pkg::OFF_ALARM_LO, lo);
    bus(1'b1, lpc_pkg::OFF_ALARM_HI, 32'h0);
    bus(1'b1, lpc_pkg::OFF_ALARM_GO, 32'h0);
    @(negedge CLK_SYS);
  endtask

  task automatic set_wake(input logic [2:0] w);
    @(posedge CLK_SYS);
    wake_cmd <= w;
    repeat (2) @(posedge CLK_SYS);
  endtask

  task automatic t_straps;
    logic [31:0] ratio [4] = '{32'h1, 32'h4, 32'h5, 32'h6};
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      chk({31'h0, PLL_BYPASS_MODE}, {31'h0, s == 0});
      chk({30'h0, PLL_MULT_SEL}, s);
      bus(1'b0, lpc_pkg::OFF_RATIO, 32'h0);
      chk(rd, ratio[s]);
      bus(1'b0, lpc_pkg::OFF_STATUS, 32'h0);
      chk({30'h0, rd[5:4]}, s);
    end
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h0);
    chk({31'h0, WATCHDOG_RESET_N}, 32'h1);
    chk({31'h0, HRESP}, 32'h0);
    chk({31'h0, HREADYOUT}, 32'h1);
    bus(1'b0, lpc_pkg::OFF_PLL_LP, 32'h0);
    chk(rd, 32'h3);
    bus(1'b0, lpc_pkg::OFF_LINK_DIS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'hFFC, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_timer;
    bus(1'b1, lpc_pkg::OFF_TIMER_LO, 32'hFFFF_FFF0);
    bus(1'b1, lpc_pkg::OFF_TIMER_HI, 32'h0);
    bus(1'b1, lpc_pkg::OFF_TIMER_GO, 32'h0);
    repeat (200) @(posedge CLK_SYS);
    bus(1'b0, lpc_pkg::OFF_TIMER_HI, 32'h0);
    chk(rd, 32'h1);
    bus(1'b0, lpc_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    bus(1'b1, lpc_pkg::OFF_TIMER_HI, 32'h7);
    bus(1'b1, lpc_pkg::OFF_TIMER_LO, 32'h0);
    repeat (40) @(posedge CLK_SYS);
    bus(1'b0, lpc_pkg::OFF_TIMER_LO, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, lpc_pkg::OFF_TIMER_HI, 32'h0);
    chk(rd, 32'h7);
    bus(1'b1, lpc_pkg::OFF_TIMER_GO, 32'h0);
    repeat (80) @(posedge CLK_SYS);
    bus(1'b0, lpc_pkg::OFF_TIMER_LO, 32'h0);
    chk({31'h0, rd >= 32'h8 && rd <= 32'hC}, 32'h1);
  endtask

  task automatic t_alarm;
    int n;
    bus(1'b1, lpc_pkg::OFF_PLL_LP, 32'h0);
    start_alarm(32'h3);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h1);
    chk({31'h0, GLOBAL_CLK_EN}, 32'h0);
    chk({30'h0, PLL_LP_STATE}, 32'h0);
    wait_run(n);
    chk({31'h0, n >= 14 && n <= 28}, 32'h1);
    chk({31'h0, GLOBAL_CLK_EN}, 32'h1);
    chk({30'h0, PLL_LP_STATE}, 32'h3);
    bus(1'b0, lpc_pkg::OFF_ALARM_LO, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, lpc_pkg::OFF_PLL_LP, 32'h3);
  endtask

  task automatic t_wake;
    int n;
    for (int i = 0; i < 3; i++) begin
      start_alarm(32'hFFFF_FFFF);
      repeat (40) @(negedge CLK_SYS);
      chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h1);
      @(posedge CLK_SYS);
      wake_cmd <= 3'h1 << i;
      wait_run(n);
      chk({31'h0, n <= 20}, 32'h1);
      set_wake(3'h0);
    end
  endtask

  task automatic t_veto;
    int n;
    set_wake(3'h1);
    start_alarm(32'hFFFF_FFFF);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h0);
    // a vetoed start still sets the alarm counting
    bus(1'b0, lpc_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    set_wake(3'h4);
    start_alarm(32'hFFFF_FFFF);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h0);
    bus(1'b1, lpc_pkg::OFF_LINK_DIS, 32'h1);
    start_alarm(32'hFFFF_FFFF);
    repeat (40) @(negedge CLK_SYS);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h1);
    set_wake(3'h5);
    wait_run(n);
    chk({31'h0, n <= 20}, 32'h1);
    set_wake(3'h0);
    bus(1'b1, lpc_pkg::OFF_LINK_DIS, 32'h0);
  endtask

  task automatic t_watchdog;
    int n;
    bus(1'b1, lpc_pkg::OFF_WD_SEL, 32'h1);
    start_alarm(32'h5);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h0);
    n = 0;
    while (WATCHDOG_RESET_N !== 1'b0 && n < 100) begin
      @(negedge CLK_SYS);
      n++;
    end
    chk({31'h0, n >= 16 && n <= 44}, 32'h1);
    n = 0;
    while (WATCHDOG_RESET_N === 1'b0 && n < 40) begin
      @(negedge CLK_SYS);
      n++;
    end
    chk(n, 32'h8);
    bus(1'b1, lpc_pkg::OFF_WD_SEL, 32'h0);
  endtask

  task automatic t_reset_down;
    start_alarm(32'hFFFF_FFFF);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h1);
    do_reset(2'h1);
    chk({31'h0, CLOCKS_STOPPED_PIN}, 32'h0);
    chk({31'h0, GLOBAL_CLK_EN}, 32'h1);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run is under a thousand cycles; this leaves ample margin
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end

  initial begin
    t_straps();
    t_timer();
    t_alarm();
    t_wake();
    t_veto();
    t_watchdog();
    t_reset_down();
    summarize();
  end
endmodule
